// ==== logic/ddrb_burst_engine.sv ====
`timescale 1ns/10ps
`default_nettype none
module ddrb_burst_engine
  import ddrb_pkg::*;
#(
  parameter int unsigned DQ_W  = DDRB_DQ_W,
  parameter int unsigned COL_W = DDRB_COL_W
) (
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire ddrb_cfg_s         CFG,
  output logic                   BUSY,
  input  wire logic              LINK_CLK,
  input  wire logic              CS_N,
  input  wire logic              RAS_N,
  input  wire logic              CAS_N,
  input  wire logic              WE_N,
  input  wire logic [COL_W-1:0]  COL_ADDR,
  input  wire logic [2*DQ_W-1:0] DQ_I,
  input  wire logic [3:0]        WMASK,
  output logic      [2*DQ_W-1:0] DQ_O,
  output logic                   DQ_OE,
  output logic      [1:0]        DQS_O,
  output logic                   DQS_OE
);

  localparam int unsigned LANES = DQ_W / 8;
  localparam int unsigned HI_W  = COL_W - 3;

  // link reset
  logic [1:0] lrst_sync_q;
  logic       lrst_n;

  // the link side leaves reset two link clocks after the core, so hold reset long enough
  // reset release crosses into the link domain through two flops
  always_ff @(posedge LINK_CLK) begin
    lrst_sync_q <= {lrst_sync_q[0], RST_N};
  end
  assign lrst_n = lrst_sync_q[1];

  // config sync
  ddrb_cfg_s cfg_s1_q;
  ddrb_cfg_s cfg_q;

  // config is quasi-static: software only changes it with the link idle,
  // so a plain two-flop level sync of the whole word is acceptable
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      cfg_s1_q <= DDRB_CFG_RST;
      cfg_q    <= DDRB_CFG_RST;
    end else begin
      cfg_s1_q <= CFG;
      cfg_q    <= cfg_s1_q;
    end
  end

  logic       bl8;
  logic       itl;
  logic [2:0] npairs;
  logic       mask_en;
  logic [3:0] lat_idx;
  logic [3:0] pre_idx;

  assign bl8     = (cfg_q.burst_len == DDRB_BL_CODE_8);
  assign itl     = (cfg_q.burst_type == DDRB_TYPE_ITL);
  assign npairs  = bl8 ? DDRB_PAIRS_BL8 : DDRB_PAIRS_BL4;
  assign mask_en = !(cfg_q.read_only_strobe_option && !cfg_q.wide);
  // read launch is one edge early because read data is registered,
  // which lands it on the same index as the write latency point
  assign lat_idx = 4'({1'b0, cfg_q.add_lat} + {1'b0, cfg_q.cas_lat} - 4'h1);
  assign pre_idx = 4'(lat_idx - 4'h1);

  // command decode
  logic rd_take;
  logic wr_take;

  assign rd_take = !CS_N && RAS_N && !CAS_N && WE_N;
  assign wr_take = !CS_N && RAS_N && !CAS_N && !WE_N;

  // posted pipeline
  ddrb_cmd_s       cmd_q [DDRB_LAT_DEPTH];
  logic [HI_W-1:0] hi_pipe_q [DDRB_LAT_DEPTH];

  // the slot count bounds the latency: additive plus column latency must not exceed it
  // each column command rides the whole line and is taken at its latency point
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      for (int i = 0; i < DDRB_LAT_DEPTH; i++) begin
        cmd_q[i]     <= '0;
        hi_pipe_q[i] <= '0;
      end
    end else begin
      cmd_q[0]     <= '{rd_take || wr_take, wr_take, COL_ADDR[2:0]};
      hi_pipe_q[0] <= COL_ADDR[COL_W-1:3];
      for (int i = 1; i < DDRB_LAT_DEPTH; i++) begin
        cmd_q[i]     <= cmd_q[i-1];
        hi_pipe_q[i] <= hi_pipe_q[i-1];
      end
    end
  end

  logic launch;
  logic pre_rd;
  logic pend_any;

  assign launch = cmd_q[lat_idx].valid;
  assign pre_rd = cmd_q[pre_idx].valid && !cmd_q[pre_idx].wr;

  always_comb begin
    pend_any = 1'b0;
    for (int i = 0; i < DDRB_LAT_DEPTH; i++) begin
      pend_any = pend_any | cmd_q[i].valid;
    end
  end

  // burst order
  // the sequential adder stays two bits wide so it wraps inside the nibble
  function automatic logic [2:0] beat_off(input logic [2:0] s, input logic [2:0] b,
                                          input logic il, input logic l8);
    logic [2:0] o;
    o = il ? (s ^ b) : {s[2] ^ b[2], 2'(s[1:0] + b[1:0])};
    if (!l8) begin
      o[2] = s[2];
    end
    return o;
  endfunction

  // beat counter
  ddrb_state_e     state_q;
  ddrb_state_e     state_d;
  logic [2:0]      start_q;
  logic [HI_W-1:0] hi_q;
  logic [2:0]      pair_q;
  logic [2:0]      pair_d;
  logic            iss;
  logic            iss_wr;
  logic [2:0]      iss_start;
  logic [HI_W-1:0] iss_hi;
  logic [2:0]      iss_pair;
  logic [2:0]      off_r;
  logic [2:0]      off_f;
  logic [COL_W-1:0] col_r;
  logic [COL_W-1:0] col_f;

  // a launch always wins over the running burst: that is both the gapless
  // follow-on and the two-clock cut of a burst of eight
  always_comb begin
    iss       = 1'b0;
    iss_wr    = 1'b0;
    iss_start = start_q;
    iss_hi    = hi_q;
    iss_pair  = pair_q;
    if (launch) begin
      iss       = 1'b1;
      iss_wr    = cmd_q[lat_idx].wr;
      iss_start = cmd_q[lat_idx].start;
      iss_hi    = hi_pipe_q[lat_idx];
      iss_pair  = 3'h0;
    end else if (state_q != DDRB_IDLE) begin
      iss       = 1'b1;
      iss_wr    = (state_q == DDRB_WRITE);
    end
  end

  assign off_r = beat_off(iss_start, {iss_pair[1:0], 1'b0}, itl, bl8);
  assign off_f = beat_off(iss_start, {iss_pair[1:0], 1'b1}, itl, bl8);
  assign col_r = {iss_hi, off_r};
  assign col_f = {iss_hi, off_f};

  // count beat pairs and fall idle at the programmed length
  always_comb begin
    pair_d  = pair_q;
    state_d = state_q;
    if (iss) begin
      pair_d = 3'(iss_pair + 3'h1);
      if (pair_d == npairs) begin
        state_d = DDRB_IDLE;
      end else begin
        state_d = iss_wr ? DDRB_WRITE : DDRB_READ;
      end
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      state_q <= DDRB_IDLE;
      pair_q  <= 3'h0;
      start_q <= 3'h0;
      hi_q    <= '0;
    end else begin
      state_q <= state_d;
      pair_q  <= pair_d;
      start_q <= iss_start;
      hi_q    <= iss_hi;
    end
  end

  // array
  // a beat masked on every lane still advances the counter
  logic [DQ_W-1:0]  mem_q [2**COL_W];
  logic             arr_we;
  logic [LANES-1:0] be_r;
  logic [LANES-1:0] be_f;

  // writes only inside a live burst; later data on the pins is dropped
  assign arr_we = iss && iss_wr;

  // lower lanes follow the lower mask, upper lanes the upper one on wide parts
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      if (cfg_q.wide && (l >= LANES / 2)) begin
        be_r[l] = !(mask_en && WMASK[1]);
        be_f[l] = !(mask_en && WMASK[3]);
      end else begin
        be_r[l] = !(mask_en && WMASK[0]);
        be_f[l] = !(mask_en && WMASK[2]);
      end
    end
  end

  // no reset on the array: storage, not control state
  always_ff @(posedge LINK_CLK) begin
    if (arr_we) begin
      for (int l = 0; l < LANES; l++) begin
        if (be_r[l]) begin
          mem_q[col_r][l*8 +: 8] <= DQ_I[l*8 +: 8];
        end
        if (be_f[l]) begin
          mem_q[col_f][l*8 +: 8] <= DQ_I[DQ_W + l*8 +: 8];
        end
      end
    end
  end

  // read drive
  // dq_o_q keeps its last pair when idle; only the enables tell whether it is valid
  logic [2*DQ_W-1:0] dq_o_q;
  logic              dq_oe_q;
  logic [1:0]        dqs_o_q;
  logic              dqs_oe_q;

  // strobe preamble one clock ahead, then data with the strobe each clock;
  // masks are never looked at here
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      dq_o_q   <= '0;
      dq_oe_q  <= 1'b0;
      dqs_o_q  <= DDRB_STRB_PRE;
      dqs_oe_q <= 1'b0;
    end else if (iss && !iss_wr) begin
      dq_o_q   <= {mem_q[col_f], mem_q[col_r]};
      dq_oe_q  <= 1'b1;
      dqs_o_q  <= DDRB_STRB_BEAT;
      dqs_oe_q <= 1'b1;
    end else if (pre_rd) begin
      dq_oe_q  <= 1'b0;
      dqs_o_q  <= DDRB_STRB_PRE;
      dqs_oe_q <= 1'b1;
    end else begin
      dq_oe_q  <= 1'b0;
      dqs_o_q  <= DDRB_STRB_PRE;
      dqs_oe_q <= 1'b0;
    end
  end

  assign DQ_O   = dq_o_q;
  assign DQ_OE  = dq_oe_q;
  assign DQS_O  = dqs_o_q;
  assign DQS_OE = dqs_oe_q;

  // busy to core
  logic busy_l_q;
  logic busy_s1_q;
  logic busy_q;

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      busy_l_q <= 1'b0;
    end else begin
      busy_l_q <= pend_any || (state_d != DDRB_IDLE);
    end
  end

  // level crossing back to the core clock
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      busy_s1_q <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      busy_s1_q <= busy_l_q;
      busy_q    <= busy_s1_q;
    end
  end
  assign BUSY = busy_q;

  // checks
  default clocking cb @(posedge LINK_CLK); endclocking
  default disable iff (!lrst_n);

  AST_BL_LEN: assert property (state_q != DDRB_IDLE |-> pair_q < npairs)
    else $error("burst ran past its length");
  AST_SEQ_NIB: assert property (iss && !itl && bl8 && iss_pair < 3'h2 |->
      off_r[2] == iss_start[2] && off_f[2] == iss_start[2])
    else $error("sequential burst left its starting nibble early");
  AST_ITL_PAIR: assert property (iss && itl |-> (off_r ^ off_f) == 3'h1)
    else $error("interleave pair differs in more than bit zero");
  AST_DECODE: assert property (rd_take |=> cmd_q[0].valid && !cmd_q[0].wr)
    else $error("read command not captured");
  AST_RD_LAT: assert property (rd_take && lat_idx == 4'h2 |-> ##4 dq_oe_q)
    else $error("read data missing at read latency three");
  AST_PREAMBLE: assert property ($rose(dqs_oe_q) && !dq_oe_q |->
      dqs_o_q == DDRB_STRB_PRE ##1 dq_oe_q && dqs_o_q == DDRB_STRB_BEAT)
    else $error("read preamble not followed by data");
  AST_WR_LAT: assert property (wr_take && lat_idx == 4'h2 |-> ##3 arr_we)
    else $error("write data not taken at write latency two");
  AST_WR_END: assert property ($fell(state_q == DDRB_WRITE) && !launch |-> !arr_we)
    else $error("data stored after write burst end");
  AST_MASK: assert property (arr_we && mask_en && WMASK[0] |-> !be_r[0])
    else $error("masked lower lane still written");
  AST_NO_MASK: assert property (arr_we && !mask_en |-> &{be_r, be_f})
    else $error("mask acted while disabled");

  // strobe framing and burst restart; a cut that kept its old count
  // would replay the tail of the old burst onto the new columns
  AST_PRE_FIRST: assert property ($rose(dqs_oe_q) |-> !dq_oe_q)
    else $error("read strobe rose together with data");
  AST_OE_BEAT: assert property (dq_oe_q |-> dqs_oe_q && dqs_o_q == DDRB_STRB_BEAT)
    else $error("read data driven without a strobe beat");
  AST_RESTART: assert property (launch && state_q != DDRB_IDLE |=> pair_q == 3'h1)
    else $error("follow-on burst did not restart its beat count");
  AST_IDLE_QUIET: assert property (!pend_any && state_q == DDRB_IDLE |=> !dq_oe_q)
    else $error("read data driven with no burst pending");
  AST_WR_QUIET: assert property (arr_we |-> !dq_oe_q)
    else $error("write beat overlaps read drive");

  // traffic shapes that the bench should reach
  COV_READ: cover property (rd_take ##1 (!rd_take && !wr_take) [*6] ##1 dq_oe_q);
  COV_WRITE: cover property (arr_we && iss_pair == 3'h0 ##1 arr_we);
  COV_CUT8: cover property (launch && bl8 && state_q != DDRB_IDLE && pair_q == 3'h2);
  COV_GAPLESS: cover property (iss && state_d == DDRB_IDLE ##1 launch);
  COV_MASKED: cover property (arr_we && !(&{be_r, be_f}));

endmodule
`default_nettype wire

// ==== logic/ddrb_pkg.sv ====
// Operation
// - only bursts of four and eight words exist; other length codes act as four
// - burst length from mode bits A0..A2, burst type from mode bit A3
// - sequential order counts up within the start nibble, then the other nibble
// - interleave order is start offset xor beat count; length four ignores bit two
// - read taken when select and column strobe low, row strobe and write high
// - first read word appears read latency clocks after the command
// - read strobe low one clock before data, data aligned to strobe edges
// - same-direction commands every half burst clocks give gapless data
// - write taken when select, column strobe and write low, row strobe high
// - write latency is read latency minus one clock
// - data presented after the programmed write burst is ignored
// - high mask with a write beat blocks storing that byte lane
// - narrow organisation disables masking while the read-only strobe option is on
// - no burst stop, and bursts of four are never interrupted; the engine still lets a new launch cut a burst of four
`default_nettype none
package ddrb_pkg;

  localparam int unsigned DDRB_LAT_DEPTH = 16;    // covers additive 6 plus column latency 7
  localparam int unsigned DDRB_DQ_W      = 16;
  localparam int unsigned DDRB_COL_W     = 10;

  localparam logic [2:0] DDRB_BL_CODE_4  = 3'h2;
  localparam logic [2:0] DDRB_BL_CODE_8  = 3'h3;
  localparam logic       DDRB_TYPE_SEQ   = 1'h0;
  localparam logic       DDRB_TYPE_ITL   = 1'h1;
  localparam logic [2:0] DDRB_PAIRS_BL4  = 3'h2;
  localparam logic [2:0] DDRB_PAIRS_BL8  = 3'h4;
  localparam logic [2:0] DDRB_CL_RST     = 3'h3;
  localparam logic [2:0] DDRB_AL_RST     = 3'h0;
  localparam logic [1:0] DDRB_STRB_PRE   = 2'h0;  // {fall half, rise half}
  localparam logic [1:0] DDRB_STRB_BEAT  = 2'h1;  // high in rise half, low in fall half

  // mode and extended mode fields as the core hands them over
  typedef struct packed {
    logic [2:0] burst_len;
    logic       burst_type;
    logic [2:0] cas_lat;
    logic [2:0] add_lat;
    logic       read_only_strobe_option;
    logic       wide;
  } ddrb_cfg_s;

  localparam ddrb_cfg_s DDRB_CFG_RST = '{DDRB_BL_CODE_4, DDRB_TYPE_SEQ, DDRB_CL_RST,
                                         DDRB_AL_RST, 1'h0, 1'h1};

  // one slot of the posted column command pipeline
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [2:0] start;
  } ddrb_cmd_s;

  typedef enum logic [1:0] {
    DDRB_IDLE  = 2'b00,
    DDRB_READ  = 2'b01,
    DDRB_WRITE = 2'b10
  } ddrb_state_e;

endpackage
`default_nettype wire

// ==== tb/ddrb_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ddrb_ctrl_model
  import ddrb_pkg::*;
(
  input  wire logic        LINK_CLK,
  output logic             CS_N,
  output logic             RAS_N,
  output logic             CAS_N,
  output logic             WE_N,
  output logic [9:0]       COL_ADDR,
  output logic [31:0]      DQ_I,
  output logic [3:0]       WMASK
);
  int unsigned cyc = 0;
  logic [35:0] sched [int unsigned];  // {mask, pair} by link cycle

  // never issues precharge, auto-precharge or burst stop, so no recovery count is kept
  initial begin
    {CS_N, RAS_N, CAS_N, WE_N} = 4'hF;
    COL_ADDR = 10'h000;
    {WMASK, DQ_I} = 36'h0;
  end

  // write pairs go out in their slot; the released bus toggles so stale data cannot pass for good data
  always @(posedge LINK_CLK) begin
    cyc <= cyc + 1;
    #1;
    if (sched.exists(cyc)) {WMASK, DQ_I} = sched[cyc];
    else {WMASK, DQ_I} = ~{WMASK, DQ_I};
  end

  // one column command for one clock; the caller sets the spacing
  task automatic cmd(input logic wr, input logic [9:0] col, output int unsigned n);
    @(posedge LINK_CLK);
    #1;
    n = cyc;
    {CS_N, RAS_N, CAS_N, WE_N} = {3'b010, ~wr};
    COL_ADDR = col;
    @(posedge LINK_CLK);
    #1;
    {CS_N, RAS_N, CAS_N, WE_N} = 4'hF;
    COL_ADDR = ~col;
  endtask
endmodule
`default_nettype wire

// ==== tb/ddrb_burst_engine_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module ddrb_burst_engine_tb
  import ddrb_pkg::*;
;
  logic        clock = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n;
  ddrb_cfg_s   cfg;
  logic        busy, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_oe, prev_oe = 1'b0;
  logic [9:0]  col, c0, c1;
  logic [31:0] dq_i, dq_o;
  logic [3:0]  wmask;
  logic [1:0]  dqs_o;
  logic [2:0]  prev_s = 3'h0;
  logic [63:0] e;
  logic [15:0] shadow [int unsigned];
  logic [63:0] expq [$];  // {due link cycle, read pair}
  int          n_fail = 0;
  int          n_compared = 0;
  int          md;

  initial forever #2 clock = ~clock;
  initial begin
    #7.3;
    forever #62.5 link_clk = ~link_clk;
  end

  ddrb_burst_engine ddrb_burst_engine_i (.CLOCK(clock), .RST_N(rst_n), .CFG(cfg), .BUSY(busy),
    .LINK_CLK(link_clk), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .COL_ADDR(col),
    .DQ_I(dq_i), .WMASK(wmask), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQS_O(dqs_o), .DQS_OE(dqs_oe));
  ddrb_ctrl_model ddrb_ctrl_model_i (.LINK_CLK(link_clk), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .WE_N(we_n), .COL_ADDR(col), .DQ_I(dq_i), .WMASK(wmask));

  function automatic logic bl8();
    return cfg.burst_len === DDRB_BL_CODE_8;
  endfunction
  function automatic int unsigned pl();
    return bl8() ? 4 : 2;
  endfunction
  function automatic int unsigned rl();
    return cfg.add_lat + cfg.cas_lat;
  endfunction
  // column offset of beat k within the eight-word group
  function automatic logic [2:0] off(input logic [2:0] s, input logic [2:0] k);
    if (cfg.burst_type === DDRB_TYPE_ITL) return s ^ k;
    return {s[2] ^ (k[2] & bl8()), s[1:0] + k[1:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, x, g);
    end
  endtask

  task automatic gap(input int unsigned c);
    repeat (c) @(posedge link_clk);
  endtask

  // one burst: writes land in the shadow, reads queue their expected pairs
  task automatic burst(input logic wr, input logic [9:0] c, input int unsigned kept, input logic mk);
    int unsigned n;
    logic [31:0] d, x;
    logic [3:0]  m;
    logic [9:0]  a;
    logic        blk, ml, mh;
    blk = cfg.read_only_strobe_option & ~cfg.wide;
    ddrb_ctrl_model_i.cmd(wr, c, n);
    for (int k = 0; k < pl(); k++) begin
      d = $urandom;
      m = mk ? 4'($urandom) : 4'h0;
      if (wr) ddrb_ctrl_model_i.sched[n + rl() + k] = {m, d};
      for (int h = 0; h < 2; h++) begin
        a = {c[9:3], off(c[2:0], 3'(2 * k + h))};
        ml = m[2 * h] & ~blk;
        mh = m[2 * h + cfg.wide] & ~blk;
        if (wr && k < kept) shadow[a] = {mh ? shadow[a][15:8] : d[16 * h + 8 +: 8],
                                         ml ? shadow[a][7:0] : d[16 * h +: 8]};
        x[16 * h +: 16] = shadow[a];
      end
      if (!wr && k < kept) expq.push_back({32'(n + 1 + rl() + k), x});
    end
  endtask

  // mode 0 single, 1 seamless every half burst, 2 interrupt after two clocks
  task automatic group(input logic wr, input int m);
    burst(wr, c0, m == 2 ? 2 : pl(), 1'b1);
    if (m > 0) begin
      gap((m == 2 ? 2 : pl()) - 2);
      burst(wr, c1, pl(), 1'b1);
    end
    gap(rl() + 8);
  endtask

  // sampling mid-cycle so the registered link outputs have settled
  always @(negedge link_clk) begin
    if (dq_oe === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : '1;
      chk("read cycle", e[63:32], ddrb_ctrl_model_i.cyc);
      chk("read pair", e[31:0], dq_o);
      chk("data strobe", 32'h5, {dqs_oe, dqs_o});
      chk("busy", 32'h1, 32'(busy));
      if (prev_oe !== 1'b1) chk("preamble", 32'h4, prev_s);
    end
    prev_oe = dq_oe;
    prev_s = {dqs_oe, dqs_o};
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // about 115 us of traffic is expected
  initial begin
    #380us;
    n_fail++;
    wrap_up();
  end

  initial begin
    void'($urandom(74111));
    cfg = DDRB_CFG_RST;
    cfg.burst_len = DDRB_BL_CODE_8;
    rst_n = 1'b0;
    repeat (8) @(posedge link_clk);
    @(posedge clock);
    #1;
    rst_n = 1'b1;
    gap(6);
    // the array has no reset, so fill the columns the tests touch
    for (int j = 0; j < 4; j++) begin
      burst(1'b1, 10'(8 * j), 4, 1'b0);
      gap(2);
    end
    gap(12);
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      #1;
      cfg = '{3'($urandom), 1'($urandom), 3'(3 + $urandom % 5), 3'($urandom % 7), 1'($urandom), 1'($urandom)};
      c0 = 10'($urandom % 32);
      c1 = 10'($urandom % 32);
      md = $urandom % 3;
      if (md == 2 && !bl8()) md = 1;
      gap(4);
      group(1'b1, md);
      group(1'b0, md);
      $display("test %0d done, mode %0d", i, md);
    end
    // command slots stay busy for the full pipeline depth, so let them drain
    gap(18);
    chk("left over", 32'h0, 32'(expq.size()));
    chk("busy", 32'h0, 32'(busy));
    wrap_up();
  end
endmodule
`default_nettype wire
